// *** rtl/ubcf_core.sv ***
// Contract
// - update crc once per data strobe edge
// - crc covers strobed words only
// - termination re-assert edge carries no data
// - crc preset to 4ABAh before first word
// - xor logic into one 16-bit register
// - crc bit n maps to line n
// - device compares host crc with own
// - crc clocked by buffer write enable; the code steps it on the buffer write request, so dropped words count too
// - one synced strobe event loads both
// - keep bursts within 131072 bytes
// - sender strobe period: any, above minimum
// - receiver takes arbitrarily slow strobes
// - stopped sender counts as paused
// - never demand another word before termination
// - device never postpones its first strobe
// - at least one word before termination
// - device signalling within bounded times
// - 90 ns mode-1 cycle is allowed
// - hold data with clock edges
// - stop strobing when recipient pauses
`timescale 1ns/1ps
`default_nettype none
module ubcf_core
  import ubcf_pkg::*;
#(
  parameter int MAX_WORDS = ubcf_pkg::MAX_BURST_WORDS,
  parameter int BUF_DEPTH = ubcf_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ubcf_pkg::ubcf_host_pins_t host_pins_i,
  input wire logic [ubcf_pkg::DATA_W-1:0] dd_i,
  output ubcf_pkg::ubcf_dev_pins_t dev_pins_o,
  output logic [ubcf_pkg::DATA_W-1:0] dd_o,
  output logic dd_oe_o,
  input wire logic cmd_start_i,
  input wire logic burst_req_i,
  input wire logic dir_in_i,
  input wire logic burst_end_i,
  input wire logic tx_valid_i,
  input wire logic [ubcf_pkg::DATA_W-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [ubcf_pkg::DATA_W-1:0] rx_data_o,
  input wire logic rx_ready_i,
  output logic crc_err_o,
  output logic crc_done_o,
  output logic overflow_o
);
  import ubcf_pkg::*;

  localparam int CNT_W = $clog2(BUF_DEPTH) + 1;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  ubcf_host_pins_t pins_s1_ff, pins_s2_ff;
  logic strb_s3_ff;
  logic [DATA_W-1:0] dd_s1_ff, dd_s2_ff;
  logic strb_edge;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_s1_ff <= HOST_PINS_IDLE;
      pins_s2_ff <= HOST_PINS_IDLE;
      strb_s3_ff <= 1'b1;
      dd_s1_ff <= '0;
      dd_s2_ff <= '0;
    end else begin
      pins_s1_ff <= host_pins_i;
      pins_s2_ff <= pins_s1_ff;
      strb_s3_ff <= pins_s2_ff.host_strobe;
      dd_s1_ff <= dd_i;
      dd_s2_ff <= dd_s1_ff;
    end
  end

  // data and strobe share the same sync depth, so the word seen with
  // the edge is the one that was on the lines when the edge arrived
  // no period bound
  assign strb_edge = pins_s2_ff.host_strobe ^ strb_s3_ff;

  // ----------------------------------------------------------------
  // receive buffer and crc step
  // ----------------------------------------------------------------
  ubcf_state_t state_ff, nxt_state;
  logic [15:0] crc_ff, nxt_crc, crc_step_in, crc_step_out;
  logic word_rx, fifo_in_ready;
  logic [CNT_W-1:0] fifo_count;

  assign word_rx = strb_edge && (state_ff == ST_OUT_XFER);

  ubcf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(word_rx),
    .in_data_i(dd_s2_ff),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i),
    .count_o(fifo_count)
  );

  ubcf_crc16 #(
    .POLY(CRC_POLY)
  ) u_crc (
    .crc_i(crc_ff),
    .data_i(crc_step_in),
    .crc_o(crc_step_out)
  );

  // ----------------------------------------------------------------
  // burst control
  // ----------------------------------------------------------------
  ubcf_dev_pins_t pins_ff, nxt_pins;
  logic [DATA_W-1:0] dd_ff, nxt_dd, host_crc_ff, nxt_host_crc;
  logic dd_oe_ff, nxt_dd_oe, tx_ready_ff, nxt_tx_ready;
  logic crc_err_ff, nxt_crc_err, crc_done_ff, nxt_crc_done;
  logic ovf_ff, nxt_ovf, is_in_ff, nxt_is_in;
  logic [WCNT_W-1:0] wcnt_ff, nxt_wcnt;
  logic [PACE_W-1:0] pace_ff, nxt_pace;
  logic stop_s, host_rdy_n_s, dmack_n_s, end_wanted, buf_near_full;

  always_comb begin
    stop_s = pins_s2_ff.stop;
    host_rdy_n_s = pins_s2_ff.host_rdy_n;
    dmack_n_s = pins_s2_ff.dmack_n;
    end_wanted = (burst_end_i || (wcnt_ff == WCNT_W'(MAX_WORDS))) && (wcnt_ff != '0);
    buf_near_full = (fifo_count >= CNT_W'(BUF_DEPTH - FIFO_SLACK));
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_dd = dd_ff;
    nxt_dd_oe = dd_oe_ff;
    nxt_tx_ready = 1'b0;
    nxt_crc = crc_ff;
    crc_step_in = dd_s2_ff;
    nxt_host_crc = host_crc_ff;
    nxt_crc_done = 1'b0;
    nxt_is_in = is_in_ff;
    nxt_wcnt = wcnt_ff;
    nxt_pace = (pace_ff != '0) ? pace_ff - PACE_W'(1) : pace_ff;
    nxt_ovf = ovf_ff;
    nxt_crc_err = crc_err_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_pins = DEV_PINS_IDLE;
        nxt_dd_oe = 1'b0;
        if (burst_req_i) begin
          nxt_pins.dmarq = 1'b1;
          nxt_is_in = dir_in_i;
          nxt_state = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (!dmack_n_s) begin
          nxt_crc = CRC_SEED;
          nxt_wcnt = '0;
          if (is_in_ff) begin
            nxt_dd_oe = 1'b1;
            nxt_pace = '0;
            nxt_state = ST_IN_SETUP;
          end else begin
            nxt_pins.dev_rdy_n = 1'b0;
            nxt_state = ST_OUT_XFER;
          end
        end
      end
      ST_IN_SETUP: begin
        if (stop_s) begin
          nxt_state = ST_IN_TERM;
        end else if (end_wanted) begin
          nxt_pins.dmarq = 1'b0;
          nxt_state = ST_IN_TERM;
        end else if (tx_ready_ff && tx_valid_i) begin
          // data changes a full hold after the edge
          nxt_dd = tx_data_i;
          nxt_pace = PACE_W'(CYC_CLKS - 1);
          nxt_state = ST_IN_XFER;
        end else begin
          // ask for data as soon as allowed
          nxt_tx_ready = (pace_ff == '0) && !host_rdy_n_s;
        end
      end
      ST_IN_XFER: begin
        if (stop_s) begin
          nxt_state = ST_IN_TERM;
        end else if ((pace_ff == '0) && !host_rdy_n_s) begin
          // paced at least CYC_CLKS per half
          nxt_pins.dev_strobe = ~pins_ff.dev_strobe;
          crc_step_in = dd_ff;
          nxt_crc = crc_step_out;
          nxt_wcnt = wcnt_ff + WCNT_W'(1);
          nxt_pace = PACE_W'(CYC_CLKS - 1);
          nxt_state = ST_IN_SETUP;
        end
        // hold the edge while recipient pauses
      end
      ST_IN_TERM: begin
        if (stop_s) begin
          nxt_pins.dmarq = 1'b0;
          nxt_pins.dev_strobe = 1'b1;
          nxt_dd_oe = 1'b0;
          nxt_state = ST_CRC_WAIT;
        end
      end
      ST_OUT_XFER: begin
        // pause early enough for the words still in flight
        nxt_pins.dev_rdy_n = buf_near_full;
        if (word_rx) begin
          // same strobe event as the buffer write request, including a word dropped when the buffer is full
          nxt_crc = crc_step_out;
          nxt_wcnt = wcnt_ff + WCNT_W'(1);
          if (!fifo_in_ready) begin
            nxt_ovf = 1'b1;
          end
        end
        if (stop_s) begin
          nxt_state = ST_OUT_TERM;
        end else if (end_wanted) begin
          nxt_pins.dmarq = 1'b0;
          nxt_state = ST_OUT_TERM;
        end
      end
      ST_OUT_TERM: begin
        nxt_pins.dev_rdy_n = 1'b1;
        if (stop_s) begin
          nxt_pins.dmarq = 1'b0;
          nxt_state = ST_CRC_WAIT;
        end
      end
      ST_CRC_WAIT: begin
        // host drives crc for either direction
        if (dmack_n_s) begin
          nxt_host_crc = dd_s2_ff;
          nxt_state = ST_CRC_CMP;
        end
      end
      ST_CRC_CMP: begin
        nxt_crc_done = 1'b1;
        if (host_crc_ff != crc_ff) begin
          nxt_crc_err = 1'b1;
        end
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // new command clears, a same-cycle error wins
    if (cmd_start_i && !(state_ff == ST_CRC_CMP && host_crc_ff != crc_ff)) begin
      nxt_crc_err = 1'b0;
    end
    if (cmd_start_i && !(word_rx && !fifo_in_ready)) begin
      nxt_ovf = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      pins_ff <= DEV_PINS_IDLE;
      dd_ff <= '0;
      dd_oe_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      crc_ff <= CRC_SEED;
      host_crc_ff <= '0;
      crc_done_ff <= 1'b0;
      crc_err_ff <= 1'b0;
      is_in_ff <= 1'b0;
      wcnt_ff <= '0;
      pace_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      dd_ff <= nxt_dd;
      dd_oe_ff <= nxt_dd_oe;
      tx_ready_ff <= nxt_tx_ready;
      crc_ff <= nxt_crc;
      host_crc_ff <= nxt_host_crc;
      crc_done_ff <= nxt_crc_done;
      crc_err_ff <= nxt_crc_err;
      is_in_ff <= nxt_is_in;
      wcnt_ff <= nxt_wcnt;
      pace_ff <= nxt_pace;
      ovf_ff <= nxt_ovf;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dev_pins_o = pins_ff;
  assign dd_o = dd_ff;
  assign dd_oe_o = dd_oe_ff;
  assign tx_ready_o = tx_ready_ff;
  assign crc_err_o = crc_err_ff;
  assign crc_done_o = crc_done_ff;
  assign overflow_o = ovf_ff;

endmodule // ubcf_core
`default_nettype wire

// *** rtl/ubcf_pkg.sv ***
package ubcf_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // least strobe half-cycle used while sending (setup and hold each)
  localparam int T_CYC_NS = 120;
  localparam int CYC_CLKS_RAW = (T_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_CLKS = (CYC_CLKS_RAW < 1) ? 1 : CYC_CLKS_RAW;
  localparam int PACE_W = 8;

  // ----------------------------------------------------------------
  // data path and crc
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  // free words kept when pausing, covers up to four late words
  localparam int FIFO_SLACK = 4;
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int MAX_BURST_BYTES = 131072;
  localparam int BYTES_PER_WORD = 2;
  localparam int MAX_BURST_WORDS = MAX_BURST_BYTES / BYTES_PER_WORD;
  localparam int WCNT_W = 17;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE,
    ST_WAIT_ACK,
    ST_IN_SETUP,
    ST_IN_XFER,
    ST_IN_TERM,
    ST_OUT_XFER,
    ST_OUT_TERM,
    ST_CRC_WAIT,
    ST_CRC_CMP
  } ubcf_state_t;

  typedef struct packed {
    logic dmack_n;
    logic stop;
    logic host_rdy_n;
    logic host_strobe;
  } ubcf_host_pins_t;

  typedef struct packed {
    logic dmarq;
    logic dev_rdy_n;
    logic dev_strobe;
  } ubcf_dev_pins_t;

  localparam ubcf_host_pins_t HOST_PINS_IDLE = '{dmack_n: 1'b1, stop: 1'b0, host_rdy_n: 1'b1, host_strobe: 1'b1};
  localparam ubcf_dev_pins_t DEV_PINS_IDLE = '{dmarq: 1'b0, dev_rdy_n: 1'b1, dev_strobe: 1'b1};

endpackage

// *** rtl/ubcf_crc16.sv ***
`timescale 1ns/1ps
`default_nettype none
module ubcf_crc16 #(
  parameter logic [15:0] POLY = 16'h1021
) (
  input wire logic [15:0] crc_i,
  input wire logic [15:0] data_i,
  output logic [15:0] crc_o
);
  // ----------------------------------------------------------------
  // one word clock of xor next-state logic, bit n to line n
  // ----------------------------------------------------------------
  logic [15:0] acc;
  logic fb;

  always_comb begin
    acc = crc_i;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      fb = acc[15] ^ data_i[i];
      acc = {acc[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    end
    crc_o = acc;
  end
endmodule // ubcf_crc16
`default_nettype wire

// *** rtl/ubcf_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module ubcf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic do_wr, do_rd;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_comb begin
    count_o = wr_ff - rd_ff;
    in_ready_o = (count_o != (AW+1)'(DEPTH));
    out_valid_o = (wr_ff != rd_ff);
    out_data_o = mem_ff[rd_ff[AW-1:0]];
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    nxt_wr = wr_ff + (AW+1)'(do_wr);
    nxt_rd = rd_ff + (AW+1)'(do_rd);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge core_clk_i) begin
    if (do_wr) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule // ubcf_fifo
`default_nettype wire

// *** verification/ubcf_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ubcf_core_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ubcf_pkg::ubcf_host_pins_t host_pins_i,
  input wire ubcf_pkg::ubcf_dev_pins_t dev_pins_o,
  input wire logic [15:0] dd_o,
  input wire logic dd_oe_o,
  input wire logic cmd_start_i,
  input wire logic burst_req_i,
  input wire logic rx_valid_o,
  input wire logic [15:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic crc_err_o,
  input wire logic crc_done_o,
  input wire logic overflow_o
);
  import ubcf_pkg::*;
  // ------------------------------------------------------------
  // burst, crc and buffer relations
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_req_cause: assert property ($rose(dev_pins_o.dmarq) |-> $past(burst_req_i))
    else $error("request raised without a start");
  a_done_pulse: assert property (crc_done_o |=> !crc_done_o)
    else $error("compare pulse too long");
  a_err_sticky: assert property (crc_err_o && !cmd_start_i |=> crc_err_o)
    else $error("crc error dropped");
  a_err_clear: assert property (cmd_start_i |=> !crc_err_o || crc_done_o)
    else $error("crc error not cleared");
  a_err_cause: assert property ($rose(crc_err_o) |-> crc_done_o)
    else $error("crc error outside compare");
  a_stop_drops: assert property (host_pins_i.stop [*5] |-> !dev_pins_o.dmarq && !dd_oe_o)
    else $error("stop not honoured");
  a_dd_hold: assert property ($changed(dev_pins_o.dev_strobe) && dd_oe_o |=> $stable(dd_o) [*2])
    else $error("data moved right after strobe");
  // termination re-assert edge may follow a pause, so stop excludes it
  a_pause_hold: assert property ((host_pins_i.host_rdy_n && !host_pins_i.stop) [*5] |->
    $stable(dev_pins_o.dev_strobe))
    else $error("strobe while host not ready");
  a_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("buffer head lost");
  cover property (crc_done_o && !crc_err_o);
  cover property ($rose(crc_err_o));
  cover property ($rose(overflow_o));
endmodule // ubcf_core_chk
bind ubcf_core ubcf_core_chk ubcf_core_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_pins_i(host_pins_i),
  .dev_pins_o(dev_pins_o), .dd_o(dd_o), .dd_oe_o(dd_oe_o), .cmd_start_i(cmd_start_i), .burst_req_i(burst_req_i),
  .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i), .crc_err_o(crc_err_o),
  .crc_done_o(crc_done_o), .overflow_o(overflow_o));
`default_nettype wire

// *** verification/ubcf_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ubcf_host_model (
  input wire logic core_clk_i,
  input wire ubcf_pkg::ubcf_dev_pins_t dev_pins_i,
  input wire logic [15:0] dd_i,
  output ubcf_pkg::ubcf_host_pins_t host_pins_o,
  output logic [15:0] dd_o
);
  import ubcf_pkg::*;
  // ------------------------------------------------------------
  // host side of the cable
  // ------------------------------------------------------------
  logic [15:0] host_crc;
  logic [15:0] rx_q[$];
  initial begin
    host_pins_o = HOST_PINS_IDLE;
    dd_o = 16'h0000;
    host_crc = CRC_SEED;
  end
  // serial form, bit n on line n
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // only edges inside the transfer phase
  always @(dev_pins_i.dev_strobe)
    if (!host_pins_o.dmack_n && dev_pins_i.dmarq && !host_pins_o.stop) begin
      host_crc = crc_step(host_crc, dd_i);
      rx_q.push_back(dd_i);
    end
  task automatic start(input logic dir);
    int k;
    k = 0;
    while (!dev_pins_i.dmarq && k++ < 200) @(posedge core_clk_i);
    // acknowledge late on purpose, off the clock edge
    #305;
    host_crc = CRC_SEED;
    rx_q = {};
    host_pins_o.dmack_n = 1'b0;
  endtask
  // pace fixed at 200 ns setup and 200 ns hold, stalls on device pause unless rude
  task automatic send(input logic [15:0] w, input logic rude);
    int k;
    k = 0;
    while (dev_pins_i.dev_rdy_n && !rude && k++ < 400) #50;
    dd_o = w;
    #200;
    host_pins_o.host_strobe = ~host_pins_o.host_strobe;
    host_crc = crc_step(host_crc, w);
    #200;
  endtask
  // stop, re-assert strobe without data, then send crc
  task automatic finish(input logic [15:0] flip);
    int k;
    k = 0;
    // pin changes kept clear of the sampling edge
    #5;
    host_pins_o.stop = 1'b1;
    while (dev_pins_i.dmarq && k++ < 100) @(posedge core_clk_i);
    #205;
    host_pins_o.host_strobe = 1'b1;
    #200;
    dd_o = host_crc ^ flip;
    host_pins_o.dmack_n = 1'b1;
    host_pins_o.host_rdy_n = 1'b1;
    #400;
    host_pins_o.stop = 1'b0;
    // released bus must not keep the crc
    dd_o = ~dd_o;
  endtask
  // host pause, called off the clock edge
  task automatic set_rdy_n(input logic v);
    host_pins_o.host_rdy_n = v;
  endtask
endmodule // ubcf_host_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ubcf_pkg::*;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  logic core_clk_i, rst_i, cmd_start_i, burst_req_i, dir_in_i, burst_end_i, tx_valid_i, rx_ready_i;
  logic dd_oe_o, tx_ready_o, rx_valid_o, crc_err_o, crc_done_o, overflow_o;
  logic [15:0] tx_data_i, dd_o, host_dd, rx_data_o, dd_bus;
  ubcf_host_pins_t host_pins;
  ubcf_dev_pins_t dev_pins;
  int n_errors, check_count, cyc;
  assign dd_bus = dd_oe_o ? dd_o : host_dd;
  ubcf_core ubcf_core_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_pins_i(host_pins), .dd_i(dd_bus),
    .dev_pins_o(dev_pins), .dd_o(dd_o), .dd_oe_o(dd_oe_o), .cmd_start_i(cmd_start_i), .burst_req_i(burst_req_i),
    .dir_in_i(dir_in_i), .burst_end_i(burst_end_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
    .crc_err_o(crc_err_o), .crc_done_o(crc_done_o), .overflow_o(overflow_o));
  ubcf_host_model ubcf_host_model_i (.core_clk_i(core_clk_i), .dev_pins_i(dev_pins), .dd_i(dd_bus),
    .host_pins_o(host_pins), .dd_o(host_dd));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict;
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic begin_burst(input logic dir);
    @(posedge core_clk_i);
    burst_req_i <= 1'b1;
    dir_in_i <= dir;
    @(posedge core_clk_i);
    burst_req_i <= 1'b0;
    ubcf_host_model_i.start(dir);
  endtask
  task automatic wait_done(input logic err);
    int k;
    k = 0;
    do @(negedge core_clk_i); while (crc_done_o !== 1'b1 && ++k < 400);
    check("crc_done", 16'(crc_done_o), 16'h0001);
    check("crc_err", 16'(crc_err_o), 16'(err));
  endtask
  task automatic end_burst(input logic [15:0] flip, input logic err);
    fork
      ubcf_host_model_i.finish(flip);
      wait_done(err);
    join
  endtask
  task automatic pulse_cmd;
    @(posedge core_clk_i);
    cmd_start_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_start_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  // buffer filled past full while drain stalls; dropped word stays in crc
  task automatic sc_out_fill;
    begin_burst(1'b0);
    for (int i = 0; i < 17; i++) ubcf_host_model_i.send(16'hA500 + 16'(i), i > 0);
    @(negedge core_clk_i);
    check("dev_rdy_n", 16'(dev_pins.dev_rdy_n), 16'h0001);
    check("overflow", 16'(overflow_o), 16'h0001);
    end_burst(16'h0000, 1'b0);
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk_i);
      check("rx_valid", 16'(rx_valid_o), 16'h0001);
      check("rx_data", rx_data_o, 16'hA500 + 16'(i));
      @(posedge core_clk_i);
      rx_ready_i <= 1'b1;
      @(posedge core_clk_i);
      rx_ready_i <= 1'b0;
    end
    @(negedge core_clk_i);
    check("rx_empty", 16'(rx_valid_o), 16'h0000);
    pulse_cmd;
    check("overflow_clr", 16'(overflow_o), 16'h0000);
  endtask
  task automatic sc_out_bad_crc;
    @(posedge core_clk_i);
    rx_ready_i <= 1'b1;
    begin_burst(1'b0);
    ubcf_host_model_i.send(16'h0001, 1'b0);
    ubcf_host_model_i.send(16'hFFFE, 1'b0);
    end_burst(16'h8000, 1'b1);
    repeat (4) @(negedge core_clk_i);
    check("err_sticky", 16'(crc_err_o), 16'h0001);
    pulse_cmd;
    check("err_clr", 16'(crc_err_o), 16'h0000);
    @(posedge core_clk_i);
    rx_ready_i <= 1'b0;
  endtask
  task automatic feed(input logic [15:0] w);
    int k;
    k = 0;
    @(posedge core_clk_i);
    tx_data_i <= w;
    tx_valid_i <= 1'b1;
    do @(negedge core_clk_i); while (tx_ready_o !== 1'b1 && ++k < 600);
    @(posedge core_clk_i);
    tx_valid_i <= 1'b0;
  endtask
  // data-in, host not ready at first, device-side end after three words
  task automatic sc_in_pause;
    int k;
    begin_burst(1'b1);
    // first word offered while the host is still paused
    @(posedge core_clk_i);
    tx_data_i <= 16'h3C00;
    tx_valid_i <= 1'b1;
    repeat (40) @(negedge core_clk_i);
    check("paused_ready", 16'(tx_ready_o), 16'h0000);
    check("paused_words", 16'(ubcf_host_model_i.rx_q.size()), 16'h0000);
    ubcf_host_model_i.set_rdy_n(1'b0);
    for (int i = 0; i < 3; i++) feed(16'h3C00 + 16'(i));
    k = 0;
    while (ubcf_host_model_i.rx_q.size() < 3 && k++ < 100) @(posedge core_clk_i);
    burst_end_i <= 1'b1;
    end_burst(16'h0000, 1'b0);
    @(posedge core_clk_i);
    burst_end_i <= 1'b0;
    for (int i = 0; i < 3; i++) check("host_word", ubcf_host_model_i.rx_q[i], 16'h3C00 + 16'(i));
  endtask
  initial begin
    rst_i = 1'b1;
    {cmd_start_i, burst_req_i, dir_in_i, burst_end_i, tx_valid_i, rx_ready_i} = 6'h00;
    tx_data_i = 16'h0000;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    sc_out_fill;
    sc_out_bad_crc;
    sc_in_pause;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
